//--- rtl/ssc_regs.sv
// Serially programmed configuration, divider and reference registers with standby control
`timescale 1ns/1ps

module ssc_regs
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ser_clk,
	input wire logic ser_data_in,
	input wire logic load_strobe_n,
	input wire logic ref_compare_freq,
	input wire logic vco_compare_freq,
	input wire logic raw_ref_phase_n,
	input wire logic raw_vco_phase_n,
	input wire logic raw_pump_src,
	input wire logic raw_pump_snk,
	input wire logic r_count_done,
	output logic ref_phase_out,
	output logic vco_phase_out,
	output logic pump_src,
	output logic pump_snk,
	output logic pump_oe,
	output logic lock_indicator,
	output logic multi_function_out,
	output logic open_drain_out,
	output logic open_drain_oe,
	output logic [1:0] pump_current_sel,
	output logic pump_step_25,
	output logic counters_run,
	output logic bias_enable,
	output logic r_jam_load,
	output logic detector_init,
	output logic ref_cmp_gated,
	output logic vco_cmp_gated,
	output logic [ssc_pkg::OSC_W-1:0] osc_mode,
	output logic [ssc_pkg::RCNT_W-1:0] r_ratio,
	output logic [ssc_pkg::NCNT_W-1:0] n_ratio,
	output logic [ssc_pkg::ACNT_W-1:0] a_ratio
);
	import ssc_pkg::*;

	// =========================================================
	// Serial clock domain
	logic [DIV_W-1:0] sr_q;
	logic [4:0] cnt_q;
	logic ser_out_q;
	logic cnt_clr_q;
	logic ser_rst_n;

	// Count clear is released only after the frame start is seen, before the first clock
	assign ser_rst_n = nrst & ~cnt_clr_q;

	// Shift in while the strobe is active; the oldest bit falls out for cascading
	always_ff @(posedge ser_clk or negedge nrst)
	begin
		if (!nrst)
			sr_q <= '0;
		else if (!load_strobe_n)
			sr_q <= {sr_q[DIV_W-2:0], ser_data_in};
	end

	// Clock count per frame, saturating so long frames never alias a valid length
	always_ff @(posedge ser_clk or negedge ser_rst_n)
	begin
		if (!ser_rst_n)
			cnt_q <= XFER_LOAD_ONLY;
		else if (!load_strobe_n && cnt_q != XFER_SAT)
			cnt_q <= cnt_q + 5'h01;
	end

	// Data out changes on the falling edge so the next device samples it cleanly
	always_ff @(negedge ser_clk or negedge nrst)
	begin
		if (!nrst)
			ser_out_q <= 1'b0;
		else
			ser_out_q <= sr_q[DIV_W-1];
	end

	// =========================================================
	// Strobe crossing into the system clock domain
	logic stb_s1_q;
	logic stb_s2_q;
	logic stb_s3_q;
	logic frame_end;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			stb_s1_q <= 1'b1;
			stb_s2_q <= 1'b1;
			stb_s3_q <= 1'b1;
		end
		else
		begin
			stb_s1_q <= load_strobe_n;
			stb_s2_q <= stb_s1_q;
			stb_s3_q <= stb_s2_q;
		end
	end

	// Shift data and count are static once the strobe is inactive and the clock is held
	assign frame_end = stb_s2_q & ~stb_s3_q;

	// Clear the count after capture; release once a new frame has begun
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_clr_q <= 1'b0;
		else if (frame_end)
			cnt_clr_q <= 1'b1;
		else if (!stb_s2_q)
			cnt_clr_q <= 1'b0;
	end

	// =========================================================
	// Register file
	logic [CFG_W-1:0] cfg_q;
	logic [DIV_W-1:0] div_q;
	logic [OSC_W-1:0] osc_q;
	logic [RCNT_W-1:0] rbuf1_q;
	logic [RCNT_W-1:0] rbuf2_q;
	logic [RCNT_W-1:0] r_ratio_q;
	logic [DIV_W-1:0] cap_sr;
	logic [4:0] cap_cnt;
	logic wr_cfg;
	logic wr_ref;
	logic wr_div;
	logic wr_load;

	assign cap_sr = sr_q;
	assign cap_cnt = cnt_q;
	assign wr_cfg = frame_end && cap_cnt == XFER_CFG;
	assign wr_ref = frame_end && cap_cnt == XFER_REF;
	assign wr_div = frame_end && cap_cnt == XFER_DIV;
	assign wr_load = frame_end && cap_cnt == XFER_LOAD_ONLY;

	// Configuration byte; other lengths leave it alone, and standby never clears it
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			cfg_q <= CFG_RST;
		else if (wr_cfg)
			cfg_q <= cap_sr[CFG_W-1:0];
	end

	// Divider bytes, with the output mode field defaulting to data out
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			div_q <= DIV_RST | ({{(DIV_W-2){1'b0}}, MFO_DATA_OUT} << DIV_MODE_LSB);
		else if (wr_div)
			div_q <= cap_sr;
	end

	// Oscillator control bits take effect at once
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			osc_q <= OSC_DIV8;
		else if (wr_ref)
			osc_q <= cap_sr[REF_OSC_LSB +: OSC_W];
	end

	// First buffer of the reference ratio
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rbuf1_q <= RCNT_RST;
		else if (wr_ref)
			rbuf1_q <= cap_sr[REF_R_LSB +: RCNT_W];
	end

	// Second buffer follows a divider write or a bare load strobe
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rbuf2_q <= RCNT_RST;
		else if (wr_div || wr_load)
			rbuf2_q <= rbuf1_q;
	end

	// =========================================================
	// Standby sequencing
	ssc_state_t state_q;
	logic standby_bit;
	logic jam_q;

	assign standby_bit = cfg_q[CFG_STANDBY_BIT];

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			state_q <= ST_RUN;
		else
		begin
			case (state_q)
				ST_RUN:
					if (standby_bit)
						state_q <= ST_STANDBY;
				ST_STANDBY:
					if (!standby_bit)
						state_q <= ST_WAIT_VCO;
				ST_WAIT_VCO:
					if (standby_bit)
						state_q <= ST_STANDBY;
					else if (vco_compare_freq)
						state_q <= ST_RUN;
				default:
					state_q <= ST_RUN;
			endcase
		end
	end

	// One-cycle jam load and detector initialise on the first VCO pulse after exit
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			jam_q <= 1'b0;
		else
			jam_q <= state_q == ST_WAIT_VCO && !standby_bit && vco_compare_freq;
	end

	// Active reference ratio changes only at a count boundary or a jam load
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			r_ratio_q <= RCNT_RST;
		else if (r_count_done || jam_q)
			r_ratio_q <= rbuf2_q;
	end

	// =========================================================
	// Output stage, all registered
	logic run_d;
	logic diff_en;
	logic pump_en;
	logic detector_polarity;
	logic lock_output_enable;
	logic port_mode;
	logic [1:0] mfo_mode;
	logic lock_raw;
	logic mfo_d;

	assign run_d = state_q == ST_RUN && !standby_bit;
	assign detector_polarity = cfg_q[CFG_POL];
	assign lock_output_enable = cfg_q[CFG_LDE];
	assign diff_en = !cfg_q[CFG_DSEL] && state_q == ST_RUN && !standby_bit;
	assign pump_en = cfg_q[CFG_DSEL] && !standby_bit && state_q != ST_STANDBY;
	assign mfo_mode = div_q[DIV_MODE_LSB +: 2];
	assign port_mode = mfo_mode == MFO_PORT;
	assign lock_raw = raw_ref_phase_n & raw_vco_phase_n;

	// Multi-function output source; the port level ignores standby
	always_comb
	begin
		case (mfo_mode)
			MFO_PORT: mfo_d = cfg_q[CFG_PORT];
			MFO_REF_FREQ: mfo_d = ref_compare_freq;
			MFO_VCO_FREQ: mfo_d = vco_compare_freq;
			default: mfo_d = ser_out_q;
		endcase
	end

	// Differential detector outputs rest high when disabled or in standby
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ref_phase_out <= 1'b1;
			vco_phase_out <= 1'b1;
		end
		else
		begin
			ref_phase_out <= diff_en ? (detector_polarity ? raw_vco_phase_n : raw_ref_phase_n) : 1'b1;
			vco_phase_out <= diff_en ? (detector_polarity ? raw_ref_phase_n : raw_vco_phase_n) : 1'b1;
		end
	end

	// Single-ended pump, swapped source and sink when inverted, floated when off
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pump_src <= 1'b0;
			pump_snk <= 1'b0;
			pump_oe <= 1'b0;
		end
		else
		begin
			pump_src <= pump_en && (detector_polarity ? raw_pump_snk : raw_pump_src);
			pump_snk <= pump_en && (detector_polarity ? raw_pump_src : raw_pump_snk);
			pump_oe <= pump_en;
		end
	end

	// Lock indicator: static low when disabled, static high in standby when enabled
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			lock_indicator <= 1'b0;
		else if (standby_bit || state_q == ST_STANDBY)
			lock_indicator <= lock_output_enable;
		else if (state_q == ST_WAIT_VCO)
			lock_indicator <= 1'b0;
		else
			lock_indicator <= lock_output_enable & lock_raw;
	end

	// General-purpose outputs; neither reacts to standby
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			multi_function_out <= 1'b0;
			open_drain_out <= 1'b0;
			open_drain_oe <= 1'b1;
		end
		else
		begin
			multi_function_out <= mfo_d;
			open_drain_out <= 1'b0;
			open_drain_oe <= !cfg_q[CFG_OUTB];
		end
	end

	// Pump current and step size
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pump_current_sel <= 2'b00;
			pump_step_25 <= 1'b0;
		end
		else
		begin
			pump_current_sel <= {cfg_q[CFG_I2], cfg_q[CFG_I1]};
			pump_step_25 <= cfg_q[CFG_PORT] && !port_mode;
		end
	end

	// Counter and bias control, compare pulse gating toward the detectors
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			counters_run <= 1'b1;
			bias_enable <= 1'b1;
			ref_cmp_gated <= 1'b0;
			vco_cmp_gated <= 1'b0;
		end
		else
		begin
			counters_run <= !standby_bit && state_q != ST_STANDBY;
			bias_enable <= !standby_bit && state_q != ST_STANDBY;
			ref_cmp_gated <= run_d && ref_compare_freq;
			vco_cmp_gated <= run_d && vco_compare_freq;
		end
	end

	// Ratios and control toward the counters and oscillator block
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_jam_load <= 1'b0;
			detector_init <= 1'b0;
			osc_mode <= OSC_DIV8;
			r_ratio <= RCNT_RST;
			n_ratio <= '0;
			a_ratio <= '0;
		end
		else
		begin
			r_jam_load <= jam_q;
			detector_init <= jam_q;
			osc_mode <= osc_q;
			r_ratio <= r_ratio_q;
			n_ratio <= div_q[DIV_N_LSB +: NCNT_W];
			a_ratio <= div_q[DIV_A_LSB +: ACNT_W];
		end
	end
endmodule

//--- rtl/ssc_pkg.sv
// Constants, field layouts and reset values for the synthesizer serial configuration registers
package ssc_pkg;
	// =========================================================
	// Transfer lengths, in serial clock cycles
	localparam logic [4:0] XFER_LOAD_ONLY = 5'h00;
	localparam logic [4:0] XFER_CFG = 5'h08;
	localparam logic [4:0] XFER_REF = 5'h10;
	localparam logic [4:0] XFER_DIV = 5'h18;
	localparam logic [4:0] XFER_SAT = 5'h19;
	// =========================================================
	// Register widths
	localparam int CFG_W = 8;
	localparam int DIV_W = 24;
	localparam int REF_W = 16;
	localparam int RCNT_W = 13;
	localparam int OSC_W = 3;
	localparam int ACNT_W = 6;
	localparam int NCNT_W = 12;
	// =========================================================
	// Configuration bit positions
	localparam int CFG_POL = 7;
	localparam int CFG_DSEL = 6;
	localparam int CFG_LDE = 5;
	localparam int CFG_STANDBY_BIT = 4;
	localparam int CFG_I2 = 3;
	localparam int CFG_I1 = 2;
	localparam int CFG_PORT = 1;
	localparam int CFG_OUTB = 0;
	// =========================================================
	// Divider register fields
	localparam int DIV_A_LSB = 0;
	localparam int DIV_N_LSB = 6;
	localparam int DIV_MODE_LSB = 22;
	// Reference register fields
	localparam int REF_R_LSB = 0;
	localparam int REF_OSC_LSB = 13;
	// =========================================================
	// Multi-function output modes (bits A23:A22)
	typedef enum logic [1:0] {
		MFO_DATA_OUT = 2'b00,
		MFO_REF_FREQ = 2'b01,
		MFO_VCO_FREQ = 2'b10,
		MFO_PORT = 2'b11
	} ssc_mfo_mode_t;
	// =========================================================
	// Reset values
	localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
	localparam logic [DIV_W-1:0] DIV_RST = 24'h000000;
	localparam logic [OSC_W-1:0] OSC_DIV8 = 3'h3;
	localparam logic [RCNT_W-1:0] RCNT_RST = 13'h0000;
	// Standby sequencing states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_STANDBY = 2'b01,
		ST_WAIT_VCO = 2'b10
	} ssc_state_t;
endpackage

//--- tb/ssc_host_model.sv
// Host model that programs the registers over the serial link
`timescale 1ns/1ps
module ssc_host_model
(
	input wire logic sys_clk,
	output logic ser_clk,
	output logic ser_data_in,
	output logic load_strobe_n
);
	import ssc_pkg::*;
	// =====================================
	// Idle link: clock parked, strobe high
	initial
	begin
		ser_clk = 1'b0;
		ser_data_in = 1'b0;
		load_strobe_n = 1'b1;
	end
	// One frame of n clocks, MSB first; link clock runs only inside it
	task automatic frame(input int n, input logic [23:0] val);
		@(negedge sys_clk);
		load_strobe_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		#3;
		for (int i = n - 1; i >= 0; i--)
		begin
			ser_data_in = val[i];
			#40 ser_clk = 1'b1;
			#40 ser_clk = 1'b0;
		end
		@(negedge sys_clk);
		load_strobe_n = 1'b1;
		ser_data_in = ~ser_data_in; // Stale data must not look valid
		repeat (8) @(negedge sys_clk); // Return off the sampling edge so checks see settled outputs
	endtask
endmodule

//--- tb/ssc_regs_chk.sv
// Port-level assertions for the serial configuration register block
`timescale 1ns/1ps
module ssc_regs_chk
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic vco_compare_freq,
	input wire logic open_drain_out,
	input wire logic ref_phase_out,
	input wire logic vco_phase_out,
	input wire logic pump_oe,
	input wire logic counters_run,
	input wire logic bias_enable,
	input wire logic r_jam_load,
	input wire logic detector_init,
	input wire logic ref_cmp_gated,
	input wire logic vco_cmp_gated
);
	// =====================================
	// Single domain, so one clocking and one disable
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	AST_OD_LOW: assert property (open_drain_out == 1'b0) else $error("od data");
	AST_STANDBY_BIT_PUMP: assert property (!counters_run |-> !pump_oe) else $error("pump on");
	AST_STANDBY_BIT_PHASE: assert property (!counters_run |-> ref_phase_out && vco_phase_out) else $error("ph");
	AST_BIAS: assert property (bias_enable == counters_run) else $error("bias");
	AST_STANDBY_BIT_GATE: assert property (!counters_run |-> !ref_cmp_gated && !vco_cmp_gated) else $error("gate");
	AST_JAM_CAUSE: assert property ($rose(r_jam_load) |-> $past(vco_compare_freq, 2)) else $error("jam");
	AST_JAM_PAIR: assert property (r_jam_load |-> detector_init ##1 !r_jam_load) else $error("init");
	AST_GATED_CAUSE: assert property (vco_cmp_gated |-> $past(vco_compare_freq)) else $error("vco");
	cover property (!counters_run);
	cover property (r_jam_load);
	cover property (vco_cmp_gated);
endmodule
bind ssc_regs ssc_regs_chk ssc_regs_chk_inst
(
	.sys_clk(sys_clk), .nrst(nrst), .vco_compare_freq(vco_compare_freq),
	.open_drain_out(open_drain_out), .ref_phase_out(ref_phase_out), .vco_phase_out(vco_phase_out),
	.pump_oe(pump_oe), .counters_run(counters_run), .bias_enable(bias_enable), .r_jam_load(r_jam_load),
	.detector_init(detector_init), .ref_cmp_gated(ref_cmp_gated), .vco_cmp_gated(vco_cmp_gated)
);

//--- tb/ssc_regs_tb_top.sv
// Self-checking bench for the serial configuration register block
`timescale 1ns/1ps
module ssc_regs_tb_top;
	import ssc_pkg::*;
	logic sys_clk, nrst, ser_clk, ser_data_in, load_strobe_n, ref_compare_freq, vco_compare_freq;
	logic r_count_done, ref_phase_out, vco_phase_out, pump_src, pump_snk, pump_oe, lock_indicator;
	logic multi_function_out, open_drain_out, open_drain_oe, pump_step_25, counters_run, bias_enable;
	logic r_jam_load, detector_init, ref_cmp_gated, vco_cmp_gated, g, rp, vp;
	logic [1:0] pump_current_sel;
	logic [OSC_W-1:0] osc_mode;
	logic [RCNT_W-1:0] r_ratio;
	logic [NCNT_W-1:0] n_ratio;
	logic [ACNT_W-1:0] a_ratio;
	int err_count, checked, seed, i, v, n, a, cfg, dv, rb1, rb2, rr, osc, sh;
	// =====================================
	// Raw phase inputs driven so swaps and the lock AND show; pump requests held
	ssc_regs ssc_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
		.load_strobe_n(load_strobe_n), .ref_compare_freq(ref_compare_freq), .vco_compare_freq(vco_compare_freq),
		.raw_ref_phase_n(rp), .raw_vco_phase_n(vp), .raw_pump_src(1'b1), .raw_pump_snk(1'b0),
		.r_count_done(r_count_done), .ref_phase_out(ref_phase_out), .vco_phase_out(vco_phase_out),
		.pump_src(pump_src), .pump_snk(pump_snk), .pump_oe(pump_oe), .lock_indicator(lock_indicator),
		.multi_function_out(multi_function_out), .open_drain_out(open_drain_out),
		.open_drain_oe(open_drain_oe), .pump_current_sel(pump_current_sel), .pump_step_25(pump_step_25),
		.counters_run(counters_run), .bias_enable(bias_enable), .r_jam_load(r_jam_load),
		.detector_init(detector_init), .ref_cmp_gated(ref_cmp_gated), .vco_cmp_gated(vco_cmp_gated),
		.osc_mode(osc_mode), .r_ratio(r_ratio), .n_ratio(n_ratio), .a_ratio(a_ratio));
	ssc_host_model ssc_host_model_inst (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
		.load_strobe_n(load_strobe_n));
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// =====================================
	// Comparison and verdict
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Output picture against the integer model, except open_drain_out, the gated compares, r_jam_load and detector_init
	task automatic check_all();
		logic st, pr, pv;
		st = cfg[4];
		pr = cfg[6] || st || (cfg[7] ? vp : rp);
		pv = cfg[6] || st || (cfg[7] ? rp : vp);
		chk("cur", pump_current_sel, cfg[3:2]);
		chk("od", open_drain_oe, !cfg[0]);
		chk("oe", pump_oe, cfg[6] && !st);
		chk("src", pump_src, cfg[6] && !st && !cfg[7]);
		chk("snk", pump_snk, cfg[6] && !st && cfg[7]);
		chk("phr", ref_phase_out, pr);
		chk("phv", vco_phase_out, pv);
		chk("lock", lock_indicator, cfg[5] && (st || rp && vp));
		chk("run", counters_run, !st);
		chk("bias", bias_enable, !st);
		chk("step", pump_step_25, cfg[1] && dv[23:22] != 3);
		chk("n", n_ratio, dv[17:6]);
		chk("a", a_ratio, dv[5:0]);
		chk("osc", osc_mode, osc);
		chk("r", r_ratio, rr);
		chk("mfo", multi_function_out, dv[23:22] == 3 ? cfg[1] : (dv[23:22] == 0 ? sh[23] : 0));
	endtask
	// One-cycle pulse on a counter input; g is the gated copy a cycle on
	task automatic pulse(input int w);
		@(negedge sys_clk);
		r_count_done = (w == 0);
		ref_compare_freq = (w == 1);
		vco_compare_freq = (w == 2);
		@(negedge sys_clk);
		g = (w == 1) ? ref_cmp_gated : vco_cmp_gated;
		{r_count_done, ref_compare_freq, vco_compare_freq} = 3'h0;
		if (w == 0)
			rr = rb2;
		repeat (3) @(negedge sys_clk);
	endtask
	// Frame through the host; the model shift register tracks what data out shows
	task automatic xfer(input int nb, input int val);
		ssc_host_model_inst.frame(nb, val[23:0]);
		sh = ((sh << nb) | (val & ((1 << nb) - 1))) & 32'h00ffffff;
	endtask
	// =====================================
	// Main sequence
	initial
	begin
		{nrst, r_count_done, ref_compare_freq, vco_compare_freq} = 4'h0;
		{err_count, checked, cfg, dv, rb1, rb2, rr, sh} = '0;
		{rp, vp} = 2'b01;
		seed = 32'h374438e8;
		osc = OSC_DIV8;
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		check_all();
		for (i = 0; i < 8; i++)
		begin
			{rp, vp} = i[1:0];
			v = $random(seed) & 8'hef;
			xfer(8, v);
			cfg = v;
			check_all();
		end
		for (i = 0; i < 7; i++)
		begin
			v = $random(seed);
			xfer(i < 5 ? 16 : (i == 5 ? 0 : 12), v);
			if (i < 5)
			begin
				osc = v[15:13];
				rb1 = v[12:0];
			end
			if (i < 4)
			begin
				n = $random(seed) & 12'hfff;
				a = $random(seed) & 6'h3f;
				if (n < a)
					n = a;
				dv = (i << 22) | (n << 6) | a;
				xfer(24, dv);
			end
			if (i != 4 && i != 6)
				rb2 = rb1;
			check_all();
			pulse(0);
			check_all();
		end
		for (i = 0; i < 3; i++)
		begin
			v = i == 2 ? cfg & 8'hef : ($random(seed) & 8'hcf) | 8'h10 | (i ? 0 : 8'h20);
			xfer(8, v);
			cfg = v;
			if (i < 2)
				check_all();
		end
		chk("wrun", counters_run, 1'b1);
		chk("wlock", lock_indicator, 1'b0);
		pulse(1);
		chk("rgate", g, 1'b0);
		@(negedge sys_clk);
		vco_compare_freq = 1'b1;
		@(negedge sys_clk);
		vco_compare_freq = 1'b0;
		for (i = 0; i < 10 && r_jam_load !== 1'b1; i++)
			@(negedge sys_clk);
		chk("jam", i < 10, 1'b1);
		rr = rb2;
		repeat (3) @(negedge sys_clk);
		check_all();
		pulse(2);
		chk("vgate", g, 1'b1);
		print_verdict();
	end
endmodule
